// ### design/acl_defines.svh
// Constant definitions for the AC-link codec access block.
`ifndef ACL_DEFINES_SVH
`define ACL_DEFINES_SVH

// Register indices as carried in the slot 1 index field.
`define ACL_IDX_POWERDOWN  7'h26
`define ACL_IDX_RISE_EN    7'h5e
`define ACL_IDX_FALL_EN    7'h60
`define ACL_IDX_IRQ_STAT   7'h62
`define ACL_IDX_FEATURE1   7'h6a
`define ACL_IDX_TEST_CTRL  7'h6e

// Field positions.
`define ACL_PD_LINK_BIT    12
`define ACL_PD_DAC_BIT     9
`define ACL_PD_ADC_BIT     8
`define ACL_F1_FWD_BIT     1

// Reset value shared by every register.
`define ACL_REG_RESET      16'h0000

// Frame layout: bit positions counted from the first bit of slot 0.
`define ACL_RX_FIRST       8'h01
`define ACL_RX_LAST        8'h38
`define ACL_DECODE_POS     8'h39

// Warm reset: least SYNC high time and the master clock rate.
`define ACL_WARM_NS        1000
`define ACL_MCLK_KHZ       24576
`define ACL_WARM_CYC       ((`ACL_WARM_NS * `ACL_MCLK_KHZ + 999999) / 1000000)

`endif

// ### design/acl_pkg.sv
// Types shared by the AC-link codec access block.
package acl_pkg;
  typedef enum logic [1:0] {MODE_STRAP, MODE_NORMAL, MODE_ATE, MODE_VENDOR} acl_mode_e;
  typedef enum logic [1:0] {LINK_RUN, LINK_DOWN, LINK_WARM} acl_link_e;
  typedef logic [6:0]  acl_idx_t;
  typedef logic [15:0] acl_word_t;
endpackage

// ### design/acl_sync2.sv
// Two flip-flop synchroniser for independent level bits.
`timescale 1ns/1ps
module acl_sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// ### design/acl_sys_side.sv
// System clock side: capture events out to the link, playback arrivals back in.
`timescale 1ns/1ps
module acl_sys_side (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Audio side
  input  wire logic cap_sample_strobe,
  input  wire logic play_fifo_low,
  output logic      play_sample_strobe,
  // Link domain
  input  wire logic play_tgl,
  output logic      cap_tgl,
  output logic      play_low
);
  logic play_s;
  logic play_prev_q;

  acl_sync2 #(.WIDTH(1)) u_play_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (play_tgl),
    .q     (play_s)
  );

  // Each captured sample flips the toggle; the link side turns edges back into events.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_tgl  <= 1'b0;
      play_low <= 1'b0;
    end else begin
      cap_tgl  <= cap_tgl ^ cap_sample_strobe;
      play_low <= play_fifo_low;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      play_prev_q        <= 1'b0;
      play_sample_strobe <= 1'b0;
    end else begin
      play_prev_q        <= play_s;
      play_sample_strobe <= play_s ^ play_prev_q;
    end
  end
endmodule

// ### design/acl_codec_link.sv
// AC-link codec access: frame tags, register access, sample requests, wake-up and test modes.
`timescale 1ns/1ps
`include "acl_defines.svh"
module acl_codec_link
  import acl_pkg::*;
(
  // Clocks and cold reset
  input  wire logic        clk,
  input  wire logic        crystal_in,
  input  wire logic        rst_n,
  // AC-link pins
  output logic             bit_clk,
  output logic             bit_clk_oe,
  output logic             sdata_in,
  output logic             sdata_in_oe,
  input  wire logic        sync,
  input  wire logic        sdata_out,
  // Interrupt sources and request
  input  wire logic [15:0] irq_src,
  output logic             irq_request_out,
  // Audio side, on clk
  input  wire logic        cap_sample_strobe,
  input  wire logic        play_fifo_low,
  output logic             play_sample_strobe,
  // Test mode
  output logic             vendor_test_active,
  output logic [15:0]      test_select
);
  acl_mode_e   mode_q;
  acl_link_e   link_q;
  logic [1:0]  strap_cnt_q;
  logic [19:0] pin_s;
  logic        sdo_s;
  logic        sync_s;
  logic        need_s;
  logic        cap_s;
  logic [15:0] irq_s;
  logic        cap_tgl;
  logic        play_low;
  logic        play_tgl_q;
  logic        bclk_q;
  logic        sdi_q;
  logic        sync_prev_q;
  logic [7:0]  bitcnt_q;
  logic [55:0] tx_q;
  logic [55:0] rx_q;
  logic [55:0] hdr;
  logic        link_up;
  logic        tick;
  logic        fstart;
  logic        decode;
  logic        dec_ok;
  logic        dec_rd;
  logic        dec_wr;
  acl_idx_t    dec_idx;
  acl_word_t   dec_data;
  logic        pend_q;
  acl_idx_t    pend_idx_q;
  acl_word_t   rd_word;
  logic        cap_prev_q;
  logic        cap_pend_q;
  logic        cap_tag;
  logic        play_req;
  logic [5:0]  warm_cnt_q;
  logic        wake_hold_q;
  logic [15:0] irq_prev_q;
  acl_word_t   pd_reg_q;
  acl_word_t   rise_q;
  acl_word_t   fall_q;
  acl_word_t   stat_q;
  acl_word_t   feat_q;
  acl_word_t   test_q;
  logic        irq_q;
  logic        vendor_q;

  function automatic logic wr_hit(input logic en, input acl_idx_t cur, input acl_idx_t idx);
    return en && (cur == idx);
  endfunction

  // Every pin and the system-side levels cross two flip-flops before use.
  acl_sync2 #(.WIDTH(20)) u_pin_sync (
    .clk   (crystal_in),
    .rst_n (rst_n),
    .d     ({sdata_out, sync, play_low, cap_tgl, irq_src}),
    .q     (pin_s)
  );

  acl_sys_side u_sys (
    .clk                (clk),
    .rst_n              (rst_n),
    .cap_sample_strobe  (cap_sample_strobe),
    .play_fifo_low      (play_fifo_low),
    .play_sample_strobe (play_sample_strobe),
    .play_tgl           (play_tgl_q),
    .cap_tgl            (cap_tgl),
    .play_low           (play_low)
  );

  assign sdo_s  = pin_s[19];
  assign sync_s = pin_s[18];
  assign need_s = pin_s[17];
  assign cap_s  = pin_s[16];
  assign irq_s  = pin_s[15:0];

  // strap capture
  // Straps are read three cycles after release, once the synchronised pins show post-reset levels.
  always_ff @(posedge crystal_in or negedge rst_n) begin
    if (!rst_n) begin
      mode_q      <= MODE_STRAP;
      strap_cnt_q <= 2'h0;
    end else if (mode_q == MODE_STRAP) begin
      if (strap_cnt_q == 2'h2) begin
        mode_q <= sdo_s ? MODE_ATE : (sync_s ? MODE_VENDOR : MODE_NORMAL);
      end else begin
        strap_cnt_q <= strap_cnt_q + 2'h1;
      end
    end
  end

  assign link_up = (mode_q == MODE_NORMAL) || (mode_q == MODE_VENDOR);
  assign tick    = link_up && (link_q == LINK_RUN) && !bclk_q;
  assign fstart  = tick && sync_s && !sync_prev_q;
  assign decode  = tick && (bitcnt_q == `ACL_DECODE_POS);

  // ATE release of the link outputs
  assign bit_clk     = bclk_q;
  assign bit_clk_oe  = (mode_q != MODE_ATE);
  assign sdata_in    = sdi_q;
  assign sdata_in_oe = (mode_q != MODE_ATE);

  always_ff @(posedge crystal_in or negedge rst_n) begin
    if (!rst_n) begin
      bclk_q <= 1'b0;
    end else begin
      bclk_q <= (link_up && link_q == LINK_RUN) ? ~bclk_q : 1'b0;
    end
  end

  // Frame position and serial shifters advance on bit clock rising points.
  always_ff @(posedge crystal_in or negedge rst_n) begin
    if (!rst_n) begin
      sync_prev_q <= 1'b0;
      bitcnt_q    <= 8'h00;
      tx_q        <= '0;
      rx_q        <= '0;
    end else if (tick) begin
      sync_prev_q <= sync_s;
      if (fstart) begin
        bitcnt_q <= `ACL_RX_FIRST;
        tx_q     <= {hdr[54:0], 1'b0};
      end else begin
        bitcnt_q <= bitcnt_q + 8'h01;
        tx_q     <= {tx_q[54:0], 1'b0};
        if (bitcnt_q >= `ACL_RX_FIRST && bitcnt_q <= `ACL_RX_LAST) begin
          rx_q <= {rx_q[54:0], sdo_s};
        end
      end
    end
  end

  // wake level on the data pin
  always_ff @(posedge crystal_in or negedge rst_n) begin
    if (!rst_n) begin
      sdi_q <= 1'b0;
    end else if (!link_up || link_q != LINK_RUN) begin
      sdi_q <= wake_hold_q;
    end else if (tick) begin
      sdi_q <= fstart ? hdr[55] : tx_q[55];
    end
  end

  // only codec ID zero addresses this device
  assign dec_ok   = decode && rx_q[55] && rx_q[54] && (rx_q[41:40] == 2'h0);
  assign dec_rd   = dec_ok && !rx_q[53];
  assign dec_wr   = dec_ok && rx_q[53];
  assign dec_idx  = rx_q[38:32];
  assign dec_data = rx_q[19:4];

  always_ff @(posedge crystal_in or negedge rst_n) begin
    if (!rst_n) begin
      pend_q     <= 1'b0;
      pend_idx_q <= 7'h00;
    end else if (dec_rd) begin
      pend_q     <= 1'b1;
      pend_idx_q <= dec_idx;
    end else if (fstart) begin
      pend_q <= 1'b0;
    end
  end

  always_comb begin
    case (pend_idx_q)
      `ACL_IDX_POWERDOWN: rd_word = pd_reg_q;
      `ACL_IDX_RISE_EN:   rd_word = rise_q;
      `ACL_IDX_FALL_EN:   rd_word = fall_q;
      `ACL_IDX_IRQ_STAT:  rd_word = stat_q;
      `ACL_IDX_FEATURE1:  rd_word = feat_q;
      `ACL_IDX_TEST_CTRL: rd_word = test_q;
      default:            rd_word = 16'h0000;
    endcase
  end

  assign cap_tag  = cap_pend_q && !pd_reg_q[`ACL_PD_ADC_BIT];
  assign play_req = need_s && !pd_reg_q[`ACL_PD_DAC_BIT];

  always_comb begin
    hdr        = '0;
    hdr[55]    = 1'b1;
    hdr[54]    = pend_q;
    hdr[53]    = pend_q;
    hdr[52]    = cap_tag;
    hdr[51]    = cap_tag;
    hdr[38:32] = pend_q ? pend_idx_q : 7'h00;
    // requests independent of slot 1 tag
    hdr[31]    = ~play_req;
    hdr[30]    = ~play_req;
    hdr[19:4]  = pend_q ? rd_word : 16'h0000;
  end

  // capture sample pending
  // A sample arriving in the frame-start cycle survives the clear.
  always_ff @(posedge crystal_in or negedge rst_n) begin
    if (!rst_n) begin
      cap_prev_q <= 1'b0;
      cap_pend_q <= 1'b0;
    end else begin
      cap_prev_q <= cap_s;
      if (cap_s != cap_prev_q) begin
        cap_pend_q <= 1'b1;
      end else if (fstart && cap_tag) begin
        cap_pend_q <= 1'b0;
      end
    end
  end

  // incoming playback tags reach the system side
  always_ff @(posedge crystal_in or negedge rst_n) begin
    if (!rst_n) begin
      play_tgl_q <= 1'b0;
    end else if (decode && rx_q[55] && (rx_q[52] || rx_q[51])) begin
      play_tgl_q <= ~play_tgl_q;
    end
  end

  always_ff @(posedge crystal_in or negedge rst_n) begin
    if (!rst_n) begin
      pd_reg_q <= `ACL_REG_RESET;
      rise_q   <= `ACL_REG_RESET;
      fall_q   <= `ACL_REG_RESET;
      feat_q   <= `ACL_REG_RESET;
      test_q   <= `ACL_REG_RESET;
    end else begin
      if (wr_hit(dec_wr, dec_idx, `ACL_IDX_POWERDOWN)) begin
        pd_reg_q <= dec_data & ~(16'h0001 << `ACL_PD_LINK_BIT);
      end
      if (wr_hit(dec_wr, dec_idx, `ACL_IDX_RISE_EN)) begin
        rise_q <= dec_data;
      end
      if (wr_hit(dec_wr, dec_idx, `ACL_IDX_FALL_EN)) begin
        fall_q <= dec_data;
      end
      if (wr_hit(dec_wr, dec_idx, `ACL_IDX_FEATURE1)) begin
        feat_q <= dec_data;
      end
      if (wr_hit(dec_wr, dec_idx, `ACL_IDX_TEST_CTRL)) begin
        test_q <= dec_data;
      end
    end
  end

  // edge events into sticky status, set wins over write-one-clear
  always_ff @(posedge crystal_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_prev_q <= 16'h0000;
      stat_q     <= `ACL_REG_RESET;
      irq_q      <= 1'b0;
    end else begin
      irq_prev_q <= irq_s;
      stat_q     <= (stat_q & ~(wr_hit(dec_wr, dec_idx, `ACL_IDX_IRQ_STAT) ? dec_data : 16'h0000))
                  | (irq_s & ~irq_prev_q & rise_q) | (~irq_s & irq_prev_q & fall_q);
      irq_q      <= |stat_q;
    end
  end

  assign irq_request_out = irq_q;

  // link power state
  // The bit clock stays stopped through the whole warm pulse to avoid a false frame start.
  always_ff @(posedge crystal_in or negedge rst_n) begin
    if (!rst_n) begin
      link_q     <= LINK_RUN;
      warm_cnt_q <= 6'h00;
    end else if (link_up) begin
      warm_cnt_q <= 6'h00;
      case (link_q)
        LINK_RUN: begin
          if (dec_wr && dec_idx == `ACL_IDX_POWERDOWN && dec_data[`ACL_PD_LINK_BIT]) begin
            link_q <= LINK_DOWN;
          end
        end
        LINK_DOWN: begin
          if (sync_s) begin
            link_q <= LINK_WARM;
          end
        end
        LINK_WARM: begin
          if (!sync_s) begin
            link_q <= (warm_cnt_q >= 6'(`ACL_WARM_CYC)) ? LINK_RUN : LINK_DOWN;
          end else if (warm_cnt_q < 6'h3f) begin
            warm_cnt_q <= warm_cnt_q + 6'h01;
          end else begin
            warm_cnt_q <= warm_cnt_q;
          end
        end
        default: link_q <= LINK_RUN;
      endcase
    end
  end

  // wake forwarded onto the data pin
  always_ff @(posedge crystal_in or negedge rst_n) begin
    if (!rst_n) begin
      wake_hold_q <= 1'b0;
    end else if (link_q == LINK_DOWN && feat_q[`ACL_F1_FWD_BIT] && (|stat_q)) begin
      wake_hold_q <= 1'b1;
    end else if (link_q == LINK_WARM && !sync_s) begin
      wake_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge crystal_in or negedge rst_n) begin
    if (!rst_n) begin
      vendor_q <= 1'b0;
    end else begin
      vendor_q <= (mode_q == MODE_VENDOR);
    end
  end

  assign vendor_test_active = vendor_q;
  assign test_select        = test_q;

  property p_ate_hiz;
    @(posedge crystal_in) disable iff (!rst_n)
    (mode_q == MODE_ATE) |-> (!bit_clk_oe && !sdata_in_oe && !bit_clk);
  endproperty
  a_ate_hiz: assert property (p_ate_hiz) else $error("ATE mode drives link");

  property p_down_low;
    @(posedge crystal_in) disable iff (!rst_n)
    (link_q == LINK_DOWN && !wake_hold_q) |=> (!bit_clk && (!sdata_in || wake_hold_q));
  endproperty
  a_down_low: assert property (p_down_low) else $error("Halted link not low");

  property p_read_tags;
    @(posedge crystal_in) disable iff (!rst_n)
    (fstart && pend_q) |=> (tx_q[55:54] == 2'b11 && tx_q[39:33] == $past(pend_idx_q));
  endproperty
  a_read_tags: assert property (p_read_tags) else $error("Read answer untagged");

  property p_no_tags;
    @(posedge crystal_in) disable iff (!rst_n)
    (fstart && !pend_q) |=> (tx_q[55:54] == 2'b00 && tx_q[20:1] == 20'h00000);
  endproperty
  a_no_tags: assert property (p_no_tags) else $error("Slot 1/2 tagged without read");

  property p_req_bits;
    @(posedge crystal_in) disable iff (!rst_n)
    fstart |=> (tx_q[30:23] == 8'h00 && !tx_q[40] && tx_q[22:21] == 2'b00);
  endproperty
  a_req_bits: assert property (p_req_bits) else $error("Unused slot 1 bits set");

  property p_wake_hold;
    @(posedge crystal_in) disable iff (!rst_n)
    (wake_hold_q && $past(wake_hold_q)) |-> sdata_in;
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("Wake level dropped");

  property p_warm_exit;
    @(posedge crystal_in) disable iff (!rst_n)
    (link_up && link_q == LINK_WARM && !sync_s && warm_cnt_q >= 6'(`ACL_WARM_CYC)) |=> (link_q == LINK_RUN);
  endproperty
  a_warm_exit: assert property (p_warm_exit) else $error("Warm reset not honoured");

  property p_irq_out;
    @(posedge crystal_in) disable iff (!rst_n)
    (|stat_q) ##1 (|stat_q) |-> irq_request_out;
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("Interrupt request not raised");

  property p_test_write;
    @(posedge crystal_in) disable iff (!rst_n)
    (dec_wr && dec_idx == `ACL_IDX_TEST_CTRL) |=> (test_select == $past(dec_data));
  endproperty
  a_test_write: assert property (p_test_write) else $error("Write not applied");
endmodule

// ### dv/acl_ctrl_model.sv
// Behavioural AC-link controller: frames commands on the link and captures the codec's frames.
`timescale 1ns/1ps
module acl_ctrl_model (
  // Link pins
  input  wire logic bit_clk,
  input  wire logic sdata_in,
  output logic      sync,
  output logic      sdata_out
);
  logic [255:0] rx_frame;

  initial begin
    sync      = 1'b0;
    sdata_out = 1'b0;
  end

  // strap levels.
  // The caller holds them across the end of cold reset.
  task automatic strap(input logic so, input logic sy);
    sdata_out = so;
    sync      = sy;
  endtask

  // warm reset level.
  // SYNC is asynchronous here because the bit clock is stopped.
  task automatic sync_level(input logic v);
    sync = v;
  endtask

  // frame tags.
  // A short frame stops after slot 2, so a power-down write never waits on a dead clock.
  task automatic xfer(input logic [15:0] s0, input logic [19:0] s1, input logic [19:0] s2, input int nbits);
    logic [55:0] tx;
    int          i;
    tx = {s0, s1, s2};
    @(posedge bit_clk);
    sync <= 1'b1;
    for (i = 0; i <= nbits; i++) begin
      @(posedge bit_clk);
      sdata_out <= (i < 56) ? tx[55-i] : 1'b0;
      if (i == 15)
        sync <= 1'b0;
      // requests read untagged.
      // The codec sees SYNC through its synchroniser, so its frame trails ours by one bit clock.
      @(negedge bit_clk);
      if (i > 0)
        rx_frame[256-i] = sdata_in;
    end
  endtask
endmodule

// ### dv/acl_codec_link_tb_top.sv
// Self-checking bench for the AC-link codec access block against a controller model.
`timescale 1ns/1ps
`include "acl_defines.svh"
module acl_codec_link_tb_top import acl_pkg::*;;
  localparam int timeout_cyc = 80000;
  logic         clk, crystal_in, rst_n, bclk_w, sdi_w;
  logic         bit_clk, bit_clk_oe, sdata_in, sdata_in_oe, sync, sdata_out;
  logic [15:0]  irq_src, test_select;
  logic         irq_request_out, cap_sample_strobe, play_fifo_low, play_sample_strobe;
  logic         vendor_test_active, pend_rd;
  logic [255:0] rx;
  logic [1:0]   exp_req;
  acl_idx_t     pend_idx;
  acl_word_t    pend_dat;
  int           err_count, compares, cycles, play_cnt;

  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  // link master clock, phase unrelated to clk.
  initial begin
    crystal_in = 1'b0;
    #7;
    forever #16 crystal_in = ~crystal_in;
  end

  // Released pins float, so a stale level can never pass for a driven one.
  assign bclk_w = bit_clk_oe ? bit_clk : 1'bz;
  assign sdi_w  = sdata_in_oe ? sdata_in : 1'bz;

  acl_codec_link u_dut (
    .clk(clk), .crystal_in(crystal_in), .rst_n(rst_n),
    .bit_clk(bit_clk), .bit_clk_oe(bit_clk_oe), .sdata_in(sdata_in), .sdata_in_oe(sdata_in_oe),
    .sync(sync), .sdata_out(sdata_out), .irq_src(irq_src), .irq_request_out(irq_request_out),
    .cap_sample_strobe(cap_sample_strobe), .play_fifo_low(play_fifo_low),
    .play_sample_strobe(play_sample_strobe), .vendor_test_active(vendor_test_active),
    .test_select(test_select)
  );

  acl_ctrl_model u_ctrl (.bit_clk(bclk_w), .sdata_in(sdi_w), .sync(sync), .sdata_out(sdata_out));

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (play_sample_strobe === 1'b1)
      play_cnt <= play_cnt + 1;
    if (cycles == timeout_cyc) begin
      err_count++;
      close_out;
    end
  end

  task automatic close_out;
    $display("compares %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk_w(input logic [19:0] got, input logic [19:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_b(input logic got, input logic exp, input string what);
    chk_w({19'h0, got}, {19'h0, exp}, what);
  endtask

  task automatic chk_resp(input logic t, input acl_idx_t idx, input acl_word_t d);
    int k;
    chk_w({17'h0, rx[255:253]}, {17'h0, 1'b1, t, t}, "slot0 tags");
    chk_w({9'h0, rx[250:240]}, 20'h0, "slot0 low bits");
    chk_w(rx[239:220], {1'b0, t ? idx : 7'h00, exp_req, 10'h0}, "slot1");
    chk_w(rx[219:200], t ? {d, 4'h0} : 20'h0, "slot2");
    for (k = 0; k < 10; k++)
      chk_w(rx[199-20*k -: 20], 20'h0, "audio slot");
  endtask

  // Each frame checks the answer owed to the frame before it.
  task automatic op(input logic [15:0] s0, input acl_idx_t idx, input acl_word_t wd, input logic is_rd,
                    input acl_word_t exp, input int nbits = 256);
    u_ctrl.xfer(s0, {is_rd, idx, 12'h0}, {wd, 4'h0}, nbits);
    rx = u_ctrl.rx_frame;
    chk_resp(pend_rd, pend_idx, pend_dat);
    pend_rd  = is_rd;
    pend_idx = idx;
    pend_dat = exp;
  endtask

  task automatic rd(input acl_idx_t idx, input acl_word_t exp);
    op(16'hc000, idx, 16'h0000, 1'b1, exp);
  endtask

  task automatic wr(input acl_idx_t idx, input acl_word_t wd);
    op(16'he000, idx, wd, 1'b0, 16'h0000);
  endtask

  task automatic idle;
    op(16'h8000, 7'h00, 16'h0000, 1'b0, 16'h0000);
  endtask

  task automatic cold(input logic so, input logic sy);
    u_ctrl.strap(so, sy);
    @(negedge clk) rst_n = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    #400;
    u_ctrl.strap(1'b0, 1'b0);
    #400;
    pend_rd = 1'b0;
  endtask

  task automatic t_regs;
    acl_idx_t  idx [6] = '{`ACL_IDX_RISE_EN, `ACL_IDX_FALL_EN, `ACL_IDX_IRQ_STAT,
                           `ACL_IDX_FEATURE1, `ACL_IDX_TEST_CTRL, 7'h10};
    acl_word_t val [6] = '{16'ha5c3, 16'h3c5a, 16'hffff, 16'h5a5d, 16'h1234, 16'hbeef};
    acl_word_t exp [6] = '{16'ha5c3, 16'h3c5a, 16'h0000, 16'h5a5d, 16'h1234, 16'h0000};
    int k;
    for (k = 0; k < 6; k++)
      rd(idx[k], `ACL_REG_RESET);
    for (k = 0; k < 6; k++)
      wr(idx[k], val[k]);
    for (k = 0; k < 6; k++)
      rd(idx[k], exp[k]);
    chk_w({4'h0, test_select}, 20'h01234, "test select");
  endtask

  task automatic t_ignore;
    logic [15:0] bad [5] = '{16'he001, 16'he002, 16'he003, 16'h6000, 16'ha000};
    int k;
    for (k = 0; k < 5; k++)
      op(bad[k], `ACL_IDX_RISE_EN, 16'h0bad, 1'b0, 16'h0000);
    op(16'hc003, `ACL_IDX_RISE_EN, 16'h0000, 1'b0, 16'h0000);
    rd(`ACL_IDX_RISE_EN, 16'ha5c3);
  endtask

  task automatic t_slotreq;
    @(negedge clk) play_fifo_low = 1'b1;
    #300;
    exp_req = 2'b00;
    idle;
    wr(`ACL_IDX_POWERDOWN, 16'h0001 << `ACL_PD_DAC_BIT);
    exp_req = 2'b11;
    idle;
    wr(`ACL_IDX_POWERDOWN, 16'h0000);
    exp_req = 2'b00;
    idle;
    @(negedge clk) play_fifo_low = 1'b0;
    #300;
    exp_req = 2'b11;
    idle;
  endtask

  task automatic t_capture;
    int k, n;
    for (k = 0; k < 2; k++) begin
      if (k == 1)
        wr(`ACL_IDX_POWERDOWN, 16'h0001 << `ACL_PD_ADC_BIT);
      @(negedge clk) cap_sample_strobe = 1'b1;
      @(negedge clk) cap_sample_strobe = 1'b0;
      n = 0;
      repeat (3) begin
        idle;
        n += (rx[252:251] === 2'b11);
      end
      chk_w(n[19:0], (k == 0) ? 20'h1 : 20'h0, "capture frames");
    end
    wr(`ACL_IDX_POWERDOWN, 16'h0000);
    play_cnt = 0;
    op(16'h9800, 7'h00, 16'h0000, 1'b0, 16'h0000);
    idle;
    chk_w(play_cnt[19:0], 20'h1, "playback strobes");
  endtask

  task automatic t_wake;
    int k;
    wr(`ACL_IDX_RISE_EN, 16'h0001);
    wr(`ACL_IDX_FALL_EN, 16'h0002);
    wr(`ACL_IDX_FEATURE1, 16'h0001 << `ACL_F1_FWD_BIT);
    wr(`ACL_IDX_IRQ_STAT, 16'hffff);
    op(16'he000, `ACL_IDX_POWERDOWN, 16'h0001 << `ACL_PD_LINK_BIT, 1'b0, 16'h0000, 56);
    for (k = 0; k < 4; k++) begin
      #200;
      chk_b(bit_clk, 1'b0, "halted clock");
      chk_b(sdata_in, 1'b0, "halted data");
    end
    chk_b(irq_request_out, 1'b0, "irq idle");
    @(negedge clk) irq_src[0] = 1'b1;
    #500;
    chk_b(irq_request_out, 1'b1, "irq raised");
    chk_b(sdata_in, 1'b1, "wake level");
    #1000;
    chk_b(sdata_in, 1'b1, "wake level held");
    u_ctrl.sync_level(1'b1);
    #600;
    u_ctrl.sync_level(1'b0);
    #1000;
    chk_b(bit_clk, 1'b0, "short sync pulse");
    u_ctrl.sync_level(1'b1);
    for (k = 0; k < 4; k++) begin
      #300;
      chk_b(bit_clk, 1'b0, "clock during warm reset");
    end
    u_ctrl.sync_level(1'b0);
    #500;
    rd(`ACL_IDX_IRQ_STAT, 16'h0001);
    // The answer is built at the next frame start, so that frame must pass before the next event.
    idle;
    @(negedge clk) irq_src[1] = 1'b0;
    #500;
    rd(`ACL_IDX_IRQ_STAT, 16'h0003);
    wr(`ACL_IDX_IRQ_STAT, 16'h0001);
    rd(`ACL_IDX_IRQ_STAT, 16'h0002);
    rd(`ACL_IDX_RISE_EN, 16'h0001);
    chk_b(irq_request_out, 1'b1, "irq still raised");
    wr(`ACL_IDX_IRQ_STAT, 16'h0002);
    idle;
    chk_b(irq_request_out, 1'b0, "irq cleared");
  endtask

  task automatic t_modes;
    cold(1'b1, 1'b0);
    chk_b(bit_clk_oe, 1'b0, "clock pin released");
    chk_b(sdata_in_oe, 1'b0, "data pin released");
    cold(1'b0, 1'b1);
    chk_b(vendor_test_active, 1'b1, "vendor mode");
    chk_w({4'h0, test_select}, 20'h0, "test select reset");
    cold(1'b0, 1'b0);
    chk_b(vendor_test_active, 1'b0, "normal mode");
    chk_b(bit_clk_oe, 1'b1, "clock pin driven");
    rd(`ACL_IDX_TEST_CTRL, `ACL_REG_RESET);
    idle;
  endtask

  initial begin
    rst_n             = 1'b0;
    cap_sample_strobe = 1'b0;
    play_fifo_low     = 1'b0;
    irq_src           = 16'h0002;
    err_count         = 0;
    compares          = 0;
    cycles            = 0;
    play_cnt          = 0;
    exp_req           = 2'b11;
    pend_rd           = 1'b0;
    pend_idx          = 7'h00;
    pend_dat          = 16'h0000;
    cold(1'b0, 1'b0);
    t_regs;
    t_ignore;
    t_slotreq;
    t_capture;
    t_wake;
    t_modes;
    close_out;
  end
endmodule
